// [design/smsc_top.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - Address query returns stored 24-bit address of the user or received source.
// - Returned addresses use the currently selected radix.
// - Radix selects hexadecimal or octal for menu data fields.
// - Each source keeps a 24-bit mask applied after parity conversion.
// - Mask query returns that source's mask in the selected radix.
// - Each menu 0 to 999 has its own scope-trigger enable.
// - Scope query answers 1 when enabled, else 0.
// - Bulk off disables every menu.
// - Bulk received loads every menu address with the received address.
// - Bulk user loads every menu address with the user address.
// - Bulk zero clears data, enables scope triggers, makes addresses numeric.
// - Bulk default restores factory contents of every menu.
// - Sync pulse has an enable for each of four interrogation types.
// - Sync query answers 1 when enabled for that type, else 0.
// - Sync pulse offset from P1 edge, -9.95 to +9.95 us, 0.05 us steps.
// - Offset query returns programmed offset.
// - Burst command acts like the burst key and gives no reply.
module smsc_top
    import smsc_pkg::*;
#(
    parameter int MENUS = SMSC_MENU_COUNT,
    parameter int SYNC_WIDTH_CYC = SMSC_SYNC_WIDTH_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [31:0] cmd_rdata,
    input wire logic [23:0] rx_addr,
    input wire logic rx_addr_valid,
    input wire logic interr_trig,
    input wire logic [1:0] interr_type,
    output logic radix_oct,
    output logic [23:0] ap_user,
    output logic [23:0] ap_rcv,
    output logic [MENUS-1:0] scope_enables,
    output smsc_bulk_out_type bulk,
    output logic burst_pulse,
    output logic sync_pulse,
    output logic cmd_reject
);
    generate
        if (MENUS < 1 || MENUS > 1024) begin : g_bad
            $error("smsc_top: MENUS must be 1 to 1024");
        end
    endgenerate

    typedef struct packed {
        logic radix_oct;
        logic [23:0] user_addr;
        logic [23:0] rcv_addr;
        logic [23:0] mask_user;
        logic [23:0] mask_rcv;
        logic [23:0] ap_user;
        logic [23:0] ap_rcv;
        logic [9:0] scope_idx;
        logic [3:0] sync_en;
        logic [8:0] dev;
        logic burst;
        smsc_bulk_out_type bulk;
        logic reject;
        logic [31:0] rdata;
    } smsc_state_type;

    smsc_state_type state_reg;
    smsc_state_type state_next;
    smsc_cmd_type cmd;
    logic scope_bit;
    logic scope_wr;
    logic data_ok;
    logic signed [31:0] dev_val;

    always_comb begin
        cmd = '{wr: cmd_wr, rd: cmd_rd, addr: cmd_addr, wdata: cmd_wdata};
        data_ok = smsc_radix_ok(cmd.wdata, state_reg.radix_oct);
        dev_val = $signed(cmd.wdata);
        scope_wr = cmd.wr && (cmd.addr == SMSC_OFS_SCOPE_STATE);
    end

    always_comb begin
        state_next = state_reg;
        state_next.burst = 1'b0;
        state_next.bulk.off = 1'b0;
        state_next.bulk.load = 1'b0;
        state_next.bulk.zero = 1'b0;
        state_next.bulk.dflt = 1'b0;
        state_next.rdata = 32'h0000_0000;
        if (rx_addr_valid) begin
            state_next.rcv_addr = rx_addr;
        end
        if (cmd.wr) begin
            case (cmd.addr)
                SMSC_OFS_RADIX: begin
                    state_next.radix_oct = cmd.wdata[0];
                end
                SMSC_OFS_USER_ADDR: begin
                    if (data_ok) begin
                        state_next.user_addr = smsc_from_radix(cmd.wdata, state_reg.radix_oct);
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
                SMSC_OFS_MASK_USER: begin
                    if (data_ok) begin
                        state_next.mask_user = smsc_from_radix(cmd.wdata, state_reg.radix_oct);
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
                SMSC_OFS_MASK_RCV: begin
                    if (data_ok) begin
                        state_next.mask_rcv = smsc_from_radix(cmd.wdata, state_reg.radix_oct);
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
                SMSC_OFS_SCOPE_IDX: begin
                    if (cmd.wdata < 32'(MENUS)) begin
                        state_next.scope_idx = cmd.wdata[9:0];
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
                SMSC_OFS_SET_ALL: begin
                    case (cmd.wdata[2:0])
                        SMSC_ALL_OFF: begin
                            state_next.bulk.off = 1'b1;
                        end
                        SMSC_ALL_RCV: begin
                            state_next.bulk.load = 1'b1;
                            state_next.bulk.addr = state_reg.rcv_addr;
                        end
                        SMSC_ALL_USER: begin
                            state_next.bulk.load = 1'b1;
                            state_next.bulk.addr = state_reg.user_addr;
                        end
                        SMSC_ALL_ZERO: begin
                            state_next.bulk.zero = 1'b1;
                        end
                        SMSC_ALL_DEFAULT: begin
                            state_next.bulk.dflt = 1'b1;
                        end
                        default: begin
                            state_next.reject = 1'b1;
                        end
                    endcase
                    if (cmd.wdata[31:3] != 29'h0) begin
                        state_next.bulk.off = 1'b0;
                        state_next.bulk.load = 1'b0;
                        state_next.bulk.zero = 1'b0;
                        state_next.bulk.dflt = 1'b0;
                        state_next.reject = 1'b1;
                    end
                end
                SMSC_OFS_DEV: begin
                    if (dev_val >= -SMSC_DEV_MAX_STEPS && dev_val <= SMSC_DEV_MAX_STEPS) begin
                        state_next.dev = cmd.wdata[8:0];
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
                SMSC_OFS_BURST: begin
                    state_next.burst = 1'b1;
                end
                SMSC_OFS_STATUS: begin
                    state_next.reject = 1'b0;
                end
                default: begin
                    if (cmd.addr[7:4] == SMSC_OFS_SYNC_EN[7:4] && cmd.addr[1:0] == 2'b00) begin
                        state_next.sync_en[cmd.addr[3:2]] = cmd.wdata[0];
                    end
                end
            endcase
        end
        if (cmd.rd) begin
            case (cmd.addr)
                SMSC_OFS_RADIX: begin
                    state_next.rdata = {31'h0000_0000, state_reg.radix_oct};
                end
                SMSC_OFS_USER_ADDR: begin
                    state_next.rdata = smsc_to_radix(state_reg.user_addr, state_reg.radix_oct);
                end
                SMSC_OFS_RCV_ADDR: begin
                    state_next.rdata = smsc_to_radix(state_reg.rcv_addr, state_reg.radix_oct);
                end
                SMSC_OFS_MASK_USER: begin
                    state_next.rdata = smsc_to_radix(state_reg.mask_user, state_reg.radix_oct);
                end
                SMSC_OFS_MASK_RCV: begin
                    state_next.rdata = smsc_to_radix(state_reg.mask_rcv, state_reg.radix_oct);
                end
                SMSC_OFS_SCOPE_IDX: begin
                    state_next.rdata = {22'h00_0000, state_reg.scope_idx};
                end
                SMSC_OFS_SCOPE_STATE: begin
                    state_next.rdata = {31'h0000_0000, scope_bit};
                end
                SMSC_OFS_DEV: begin
                    state_next.rdata = 32'($signed(state_reg.dev));
                end
                SMSC_OFS_STATUS: begin
                    state_next.rdata = {31'h0000_0000, state_reg.reject};
                end
                default: begin
                    if (cmd.addr[7:4] == SMSC_OFS_SYNC_EN[7:4] && cmd.addr[1:0] == 2'b00) begin
                        state_next.rdata = {31'h0000_0000, state_reg.sync_en[cmd.addr[3:2]]};
                    end
                end
            endcase
        end
        state_next.ap_user = smsc_addr_parity(state_next.user_addr) ^ state_next.mask_user;
        state_next.ap_rcv = smsc_addr_parity(state_next.rcv_addr) ^ state_next.mask_rcv;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.radix_oct <= SMSC_RST_RADIX_OCT;
            state_reg.user_addr <= SMSC_RST_ADDR;
            state_reg.rcv_addr <= SMSC_RST_ADDR;
            state_reg.mask_user <= SMSC_RST_MASK;
            state_reg.mask_rcv <= SMSC_RST_MASK;
            state_reg.ap_user <= SMSC_RST_AP;
            state_reg.ap_rcv <= SMSC_RST_AP;
            state_reg.sync_en <= SMSC_RST_SYNC_EN;
            state_reg.dev <= SMSC_RST_DEV;
        end else begin
            state_reg <= state_next;
        end
    end

    smsc_scope #(.MENUS(MENUS)) u_scope (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wr_en(scope_wr),
        .idx(state_reg.scope_idx),
        .wval(cmd.wdata[0]),
        .all_on(state_reg.bulk.zero),
        .all_default(state_reg.bulk.dflt),
        .rd_bit(scope_bit),
        .enables(scope_enables)
    );

    smsc_sync #(.WIDTH_CYC(SYNC_WIDTH_CYC)) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .trig(interr_trig),
        .itype(interr_type),
        .type_en(state_reg.sync_en),
        .dev(state_reg.dev),
        .pulse(sync_pulse)
    );

    assign cmd_rdata = state_reg.rdata;
    assign radix_oct = state_reg.radix_oct;
    assign ap_user = state_reg.ap_user;
    assign ap_rcv = state_reg.ap_rcv;
    assign bulk = state_reg.bulk;
    assign burst_pulse = state_reg.burst;
    assign cmd_reject = state_reg.reject;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence burst_cmd_s;
        cmd_wr && cmd_addr == SMSC_OFS_BURST;
    endsequence
    sequence burst_once_s;
        burst_pulse ##1 (!burst_pulse || $past(cmd_wr && cmd_addr == SMSC_OFS_BURST));
    endsequence

    addr_radix_a: assert property (cmd_rd && cmd_addr == SMSC_OFS_USER_ADDR
        |=> cmd_rdata == smsc_to_radix($past(state_reg.user_addr), $past(radix_oct)))
        else $error("address read not in selected radix");
    mask_query_a: assert property (cmd_rd && cmd_addr == SMSC_OFS_MASK_RCV
        |=> cmd_rdata == smsc_to_radix($past(state_reg.mask_rcv), $past(radix_oct)))
        else $error("mask read wrong");
    ap_mask_a: assert property (ap_user == (smsc_addr_parity(state_reg.user_addr) ^ state_reg.mask_user))
        else $error("user parity field wrong");
    burst_pulse_a: assert property (burst_cmd_s |=> burst_once_s)
        else $error("burst pulse not one cycle");
    burst_silent_a: assert property (cmd_rd && cmd_addr == SMSC_OFS_BURST |=> cmd_rdata == 32'h0000_0000)
        else $error("burst register answered");
    bulk_user_a: assert property (cmd_wr && cmd_addr == SMSC_OFS_SET_ALL && cmd_wdata == 32'h0000_0002
        |=> bulk.load && bulk.addr == $past(state_reg.user_addr)) else $error("bulk user load wrong");
    dev_reject_a: assert property (cmd_wr && cmd_addr == SMSC_OFS_DEV && $signed(cmd_wdata) > 199
        |=> cmd_reject && $stable(state_reg.dev)) else $error("bad offset accepted");
    sync_query_a: assert property (cmd_rd && cmd_addr == 8'h24
        |=> cmd_rdata == {31'h0000_0000, $past(state_reg.sync_en[1])}) else $error("sync query wrong");
endmodule // smsc_top

// [design/smsc_pkg.sv]
package smsc_pkg;
    // Register byte offsets of the command port.
    localparam logic [7:0] SMSC_OFS_RADIX = 8'h00;
    localparam logic [7:0] SMSC_OFS_USER_ADDR = 8'h04;
    localparam logic [7:0] SMSC_OFS_RCV_ADDR = 8'h08;
    localparam logic [7:0] SMSC_OFS_MASK_USER = 8'h0C;
    localparam logic [7:0] SMSC_OFS_MASK_RCV = 8'h10;
    localparam logic [7:0] SMSC_OFS_SCOPE_IDX = 8'h14;
    localparam logic [7:0] SMSC_OFS_SCOPE_STATE = 8'h18;
    localparam logic [7:0] SMSC_OFS_SET_ALL = 8'h1C;
    localparam logic [7:0] SMSC_OFS_SYNC_EN = 8'h20;
    localparam logic [7:0] SMSC_OFS_DEV = 8'h30;
    localparam logic [7:0] SMSC_OFS_BURST = 8'h34;
    localparam logic [7:0] SMSC_OFS_STATUS = 8'h38;

    // Reset values.
    localparam logic SMSC_RST_RADIX_OCT = 1'b0;
    localparam logic [23:0] SMSC_RST_ADDR = 24'h00_0000;
    localparam logic [23:0] SMSC_RST_MASK = 24'h00_0000;
    localparam logic [3:0] SMSC_RST_SYNC_EN = 4'h0;
    localparam logic [8:0] SMSC_RST_DEV = 9'h000;
    localparam logic SMSC_RST_SCOPE = 1'b1;
    // Parity field of the reset address under the reset mask.
    localparam logic [23:0] SMSC_RST_AP = 24'h00_0000;

    // Address-to-parity generator polynomial, low 24 bits.
    localparam logic [23:0] SMSC_AP_POLY = 24'hFF_F409;

    // Menu count, sync offset range and timing.
    localparam int SMSC_MENU_COUNT = 1000;
    localparam int SMSC_DEV_MAX_STEPS = 199;
    localparam int SMSC_STEP_NS = 50;
    localparam int SMSC_CLK_NS = 40;
    localparam int SMSC_LEAD_NS = 9950;
    localparam int SMSC_SYNC_WIDTH_NS = 1000;
    localparam int SMSC_SYNC_WIDTH_CYC = (SMSC_SYNC_WIDTH_NS + SMSC_CLK_NS - 1) / SMSC_CLK_NS;

    typedef enum logic [2:0] {
        SMSC_ALL_OFF = 3'b000,
        SMSC_ALL_RCV = 3'b001,
        SMSC_ALL_USER = 3'b010,
        SMSC_ALL_ZERO = 3'b011,
        SMSC_ALL_DEFAULT = 3'b100
    } smsc_bulk_type;

    typedef enum logic [1:0] {
        SMSC_IT_ATC = 2'b00,
        SMSC_IT_MODES = 2'b01,
        SMSC_IT_SHORT = 2'b10,
        SMSC_IT_LONG = 2'b11
    } smsc_itype_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } smsc_cmd_type;

    typedef struct packed {
        logic off;
        logic load;
        logic zero;
        logic dflt;
        logic [23:0] addr;
    } smsc_bulk_out_type;

    // Spreads each octal digit into a nibble when octal is selected.
    function automatic logic [31:0] smsc_to_radix(input logic [23:0] v, input logic oct);
        logic [31:0] r;
        r = {8'h00, v};
        if (oct) begin
            for (int i = 0; i < 8; i++) begin
                r[4*i +: 4] = {1'b0, v[3*i +: 3]};
            end
        end
        return r;
    endfunction

    function automatic logic [23:0] smsc_from_radix(input logic [31:0] d, input logic oct);
        logic [23:0] r;
        r = d[23:0];
        if (oct) begin
            for (int i = 0; i < 8; i++) begin
                r[3*i +: 3] = d[4*i +: 3];
            end
        end
        return r;
    endfunction

    function automatic logic smsc_radix_ok(input logic [31:0] d, input logic oct);
        logic ok;
        ok = (d[31:24] == 8'h00);
        if (oct) begin
            ok = 1'b1;
            for (int i = 0; i < 8; i++) begin
                if (d[4*i+3]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction

    // Divides the address by the generator to form the parity field.
    function automatic logic [23:0] smsc_addr_parity(input logic [23:0] a);
        logic [23:0] c;
        c = 24'h00_0000;
        for (int i = 23; i >= 0; i--) begin
            if (c[23] ^ a[i]) begin
                c = {c[22:0], 1'b0} ^ SMSC_AP_POLY;
            end else begin
                c = {c[22:0], 1'b0};
            end
        end
        return c;
    endfunction
endpackage

// [design/smsc_scope.sv]
`timescale 1ns/1ns
module smsc_scope
    import smsc_pkg::*;
#(
    parameter int MENUS = SMSC_MENU_COUNT
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [9:0] idx,
    input wire logic wval,
    input wire logic all_on,
    input wire logic all_default,
    output logic rd_bit,
    output logic [MENUS-1:0] enables
);
    generate
        if (MENUS < 1 || MENUS > 1024) begin : g_bad
            $error("smsc_scope: MENUS must be 1 to 1024");
        end
    endgenerate

    typedef struct packed {
        logic [MENUS-1:0] bits;
    } smsc_scope_state_type;

    smsc_scope_state_type state_reg;
    smsc_scope_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (all_on) begin
            state_next.bits = '1;
        end else if (all_default) begin
            state_next.bits = {MENUS{SMSC_RST_SCOPE}};
        end else if (wr_en && (32'(idx) < MENUS)) begin
            state_next.bits[idx] = wval;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{bits: {MENUS{SMSC_RST_SCOPE}}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_bit = (32'(idx) < MENUS) ? state_reg.bits[idx] : 1'b0;
    assign enables = state_reg.bits;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    scope_write_a: assert property (wr_en && !all_on && !all_default && 32'(idx) < MENUS
        |=> state_reg.bits[$past(idx)] == $past(wval)) else $error("scope enable write lost");
    scope_zero_a: assert property (all_on |=> &state_reg.bits)
        else $error("zero did not enable all scope triggers");
endmodule // smsc_scope

// [design/smsc_sync.sv]
`timescale 1ns/1ns
module smsc_sync
    import smsc_pkg::*;
#(
    parameter int WIDTH_CYC = SMSC_SYNC_WIDTH_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic trig,
    input wire logic [1:0] itype,
    input wire logic [3:0] type_en,
    input wire logic [8:0] dev,
    output logic pulse
);
    generate
        if (WIDTH_CYC < 1 || WIDTH_CYC > 255) begin : g_bad
            $error("smsc_sync: WIDTH_CYC must be 1 to 255");
        end
    endgenerate

    typedef struct packed {
        logic busy;
        logic [9:0] cnt;
        logic [7:0] wcnt;
        logic pulse;
    } smsc_sync_state_type;

    smsc_sync_state_type state_reg;
    smsc_sync_state_type state_next;
    logic [9:0] delay;

    // Cycles from trigger to pulse: the trigger leads P1 by the full negative span.
    always_comb begin
        delay = 10'(((int'($signed(dev)) + SMSC_DEV_MAX_STEPS) * SMSC_STEP_NS) / SMSC_CLK_NS);
    end

    always_comb begin
        state_next = state_reg;
        if (state_reg.pulse) begin
            if (state_reg.wcnt == 8'h00) begin
                state_next.pulse = 1'b0;
            end else begin
                state_next.wcnt = state_reg.wcnt - 8'h01;
            end
        end
        if (state_reg.busy) begin
            if (state_reg.cnt == 10'h000) begin
                state_next.busy = 1'b0;
                state_next.pulse = 1'b1;
                state_next.wcnt = 8'(WIDTH_CYC - 1);
            end else begin
                state_next.cnt = state_reg.cnt - 10'h001;
            end
        end else if (trig && type_en[itype]) begin
            state_next.busy = 1'b1;
            state_next.cnt = delay;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pulse = state_reg.pulse;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sync_type_gate_a: assert property (trig && !state_reg.busy && !type_en[itype]
        |=> !state_reg.busy) else $error("sync started for disabled type");
    sync_offset_a: assert property (trig && !state_reg.busy && type_en[itype] && !state_reg.pulse
        |=> state_reg.busy && state_reg.cnt == $past(delay)) else $error("sync delay not loaded");
    sync_width_a: assert property ($rose(state_reg.pulse) |-> state_reg.pulse[*8])
        else $error("sync pulse too short");
endmodule // smsc_sync

// [tb/smsc_received_address_source_model.sv]
`timescale 1ns/1ns
module smsc_rcv_model (
    input wire logic sys_clk,
    output logic [23:0] rx_addr,
    output logic rx_addr_valid,
    output logic interr_trig,
    output logic [1:0] interr_type
);
    initial begin
        rx_addr = 24'h00_0000;
        rx_addr_valid = 1'b0;
        interr_trig = 1'b0;
        interr_type = 2'b00;
    end
    // Released lines show the inverse of their last value, never a held copy.
    task automatic send_addr(input logic [23:0] a);
        @(posedge sys_clk);
        rx_addr <= a;
        rx_addr_valid <= 1'b1;
        @(posedge sys_clk);
        rx_addr <= ~a;
        rx_addr_valid <= 1'b0;
    endtask
    task automatic send_trig(input logic [1:0] t);
        @(posedge sys_clk);
        interr_type <= t;
        interr_trig <= 1'b1;
        @(posedge sys_clk);
        interr_type <= ~t;
        interr_trig <= 1'b0;
    endtask
endmodule // smsc_rcv_model

// [tb/sequence_menu_sync_config_bench.sv]
`timescale 1ns/1ns
module sequence_menu_sync_config_bench
    import smsc_pkg::*;
();
    localparam logic R = 1'b0;
    localparam logic W = 1'b1;
    localparam logic [31:0] nil = 32'h0000_0000;
    localparam logic [31:0] one = 32'h0000_0001;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic rd_seen = 1'b0;
    logic [31:0] cmd_rdata, seed, ua, ex;
    logic [23:0] rx_addr, ap_user, ap_rcv;
    logic rx_addr_valid, interr_trig, radix_oct, burst_pulse, sync_pulse, cmd_reject;
    logic [1:0] interr_type;
    logic [999:0] scope_enables;
    smsc_bulk_out_type bulk;
    logic [31:0] q[$];
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #20 sys_clk = ~sys_clk;
    smsc_top uut (.sys_clk, .reset_n, .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_rdata, .rx_addr,
        .rx_addr_valid, .interr_trig, .interr_type, .radix_oct, .ap_user, .ap_rcv, .scope_enables,
        .bulk, .burst_pulse, .sync_pulse, .cmd_reject);
    smsc_rcv_model partner (.sys_clk, .rx_addr, .rx_addr_valid, .interr_trig, .interr_type);
    task automatic complete_run();
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // A read notes its expected word; the monitor compares it when the data stand.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cmd_wr <= w;
        cmd_rd <= ~w;
        cmd_addr <= a;
        cmd_wdata <= d;
        if (!w) q.push_back(d);
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
    endtask
    function automatic logic [31:0] oct(input logic [23:0] v);
        logic [31:0] r;
        for (int i = 0; i < 8; i++) r[4*i +: 4] = {1'b0, v[3*i +: 3]};
        return r;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Divides by the generator bit by bit to predict the parity field.
    function automatic logic [23:0] par(input logic [23:0] a);
        logic [23:0] c;
        c = 24'h00_0000;
        for (int i = 23; i >= 0; i--) c = {c[22:0], 1'b0} ^ ((c[23] ^ a[i]) ? SMSC_AP_POLY : 24'h00_0000);
        return c;
    endfunction
    always @(posedge sys_clk) rd_seen <= cmd_rd;
    always @(negedge sys_clk) begin
        if (rd_seen) begin
            ex = q.pop_front();
            chk("cmd_rdata", ex, cmd_rdata);
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        seed = 32'h0000_0b77;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(R, 8'h00, nil);
        seed = lfsr(seed);
        ua = {8'h00, seed[23:0]};
        bus(W, 8'h0C, ua);
        repeat (2) @(negedge sys_clk);
        chk("ap_user", ua, {8'h00, ap_user});
        bus(R, 8'h0C, ua);
        bus(W, 8'h04, ua);
        @(negedge sys_clk);
        chk("ap_user", {8'h00, par(ua[23:0]) ^ ua[23:0]}, {8'h00, ap_user});
        bus(R, 8'h04, ua);
        bus(W, 8'h00, one);
        @(negedge sys_clk);
        chk("radix_oct", one, {31'h0, radix_oct});
        bus(R, 8'h04, oct(ua[23:0]));
        bus(R, 8'h0C, oct(ua[23:0]));
        bus(W, 8'h04, 32'h0000_0008);
        bus(R, 8'h38, one);
        bus(R, 8'h04, oct(ua[23:0]));
        bus(W, 8'h00, nil);
        partner.send_addr(seed[31:8]);
        bus(R, 8'h08, {8'h00, seed[31:8]});
        bus(W, 8'h10, one);
        @(negedge sys_clk);
        chk("ap_rcv", {8'h00, par(seed[31:8]) ^ 24'h00_0001}, {8'h00, ap_rcv});
        bus(R, 8'h10, one);
        for (int i = 0; i < 1000; i += 999) begin
            bus(W, 8'h14, 32'(i));
            bus(R, 8'h18, one);
            bus(W, 8'h18, nil);
            bus(R, 8'h18, nil);
        end
        chk("scope_enables", {30'h0, 2'b01}, {30'h0, scope_enables[999:998]});
        bus(W, 8'h14, 32'h0000_03E8);
        bus(R, 8'h14, 32'h0000_03E7);
        for (int c = 0; c < 5; c++) begin
            if (c > 2) bus(W, 8'h18, nil);
            bus(W, 8'h1C, 32'(c));
            @(negedge sys_clk);
            chk("bulk", {28'h0, c == 0, c == 1 || c == 2, c == 3, c == 4}, {28'h0, bulk.off, bulk.load,
                bulk.zero, bulk.dflt});
            if (c == 1) chk("bulk_addr", {8'h00, seed[31:8]}, {8'h00, bulk.addr});
            if (c == 2) chk("bulk_addr", ua, {8'h00, bulk.addr});
            @(negedge sys_clk);
            if (c == 3) chk("scope_all", one, {31'h0, &scope_enables});
        end
        @(negedge sys_clk);
        chk("scope_all", one, {31'h0, &scope_enables});
        bus(W, 8'h24, one);
        bus(R, 8'h24, one);
        bus(R, 8'h20, nil);
        bus(W, 8'h38, nil);
        bus(R, 8'h38, nil);
        bus(W, 8'h30, 32'hFFFF_FF38);
        bus(R, 8'h38, one);
        bus(W, 8'h30, 32'hFFFF_FF39);
        bus(R, 8'h30, 32'hFFFF_FF39);
        partner.send_trig(2'b00);
        repeat (4) @(negedge sys_clk);
        chk("sync_pulse", nil, {31'h0, sync_pulse});
        partner.send_trig(2'b01);
        @(negedge sys_clk);
        chk("sync_pulse", nil, {31'h0, sync_pulse});
        @(negedge sys_clk);
        chk("sync_pulse", one, {31'h0, sync_pulse});
        repeat (24) @(negedge sys_clk);
        chk("sync_pulse", one, {31'h0, sync_pulse});
        @(negedge sys_clk);
        chk("sync_pulse", nil, {31'h0, sync_pulse});
        bus(W, 8'h34, nil);
        @(negedge sys_clk);
        chk("burst_pulse", one, {31'h0, burst_pulse});
        bus(R, 8'h34, nil);
        repeat (3) @(negedge sys_clk);
        complete_run();
    end
endmodule // sequence_menu_sync_config_bench
